// File: core/slg_stack_guard.sv
`timescale 1ns/1ns
// Contract
// [RULE_01] stack pointer holds first free word; stack grows upward
// [RULE_02] pop decrements before access; push increments after access
// [RULE_03] call pushes zero-extended program counter upper part
// [RULE_04] exception push puts status low byte above counter upper part
// [RULE_05] stack limit register has no reset value
// [RULE_06] stack limit bit 0 always reads zero; code clears it on each write, so it is unknown before the first write
// [RULE_07] stack-pointer-based addresses are compared with the limit
// [RULE_08] push at sp equal limit is fine; the next push traps
// [RULE_09] stack pointer below floor raises underflow trap
// [RULE_10] software avoids indirect stack read right after limit write
// [RULE_11] boot secure ram only for boot flash code when enabled
// [RULE_12] secure segment ram only for secure flash code when enabled
// [RULE_13] each error is one trap event and the access is not committed; a secure ram refusal only pulses ram_deny, with no stack_err trap
module slg_stack_guard (
    input wire logic clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic [3:0] op, // slg_op_t request
    input wire logic [2:0] push_src, // slg_src_t for pushes
    input wire logic [15:0] push_data, // data word to push
    input wire logic [22:0] pc, // program counter
    input wire logic [7:0] status_low_byte, // status byte for exceptions
    input wire logic [15:0] ea_in, // ea formed from stack pointer
    input wire logic lim_we, // stack limit write strobe
    input wire logic [15:0] lim_wdata, // stack limit write data
    input wire logic sp_we, // direct stack pointer write
    input wire logic [15:0] sp_wdata, // stack pointer write data
    input wire logic bs_en, // boot secure ram enable
    input wire logic [15:0] bs_lo, // boot secure ram start
    input wire logic [15:0] bs_hi, // boot secure ram end
    input wire logic ss_en, // secure segment ram enable
    input wire logic [15:0] ss_lo, // secure segment ram start
    input wire logic [15:0] ss_hi, // secure segment ram end
    input wire logic from_boot, // code in boot flash
    input wire logic from_secure, // code in secure flash
    output logic [15:0] stack_pointer_register, // current stack pointer
    output logic [15:0] stack_limit_register, // current stack limit
    output logic mem_we, // commit write to memory
    output logic mem_re, // commit read from memory
    output logic [15:0] mem_addr, // committed address
    output logic [31:0] mem_wdata, // pushed word pair, high word above
    output logic stack_err, // one-cycle stack error trap
    output logic ovf, // overflow cause flag
    output logic unf, // underflow cause flag
    output logic ram_deny // one-cycle secure ram refusal
);
    logic [15:0] sp_q, sp_d;
    logic [15:0] lim_q, lim_d;
    logic mwe_q, mwe_d, mre_q, mre_d;
    logic [15:0] madr_q, madr_d;
    logic [31:0] mwd_q, mwd_d;
    logic err_q, err_d, ovf_q, ovf_d, unf_q, unf_d, den_q, den_d;
    logic [15:0] ea;
    logic acc, deny_c, over, under;
    logic [15:0] pc_hi;
    logic pop_wrap;
    logic commit_ok;

    // pop decode for the wrap test
    function automatic logic is_pop(input logic [3:0] o);
        is_pop = (o == slg_pkg::SLG_OP_POP);
    endfunction

    // pointer advance of a push: one word for data, two for a counter pair
    function automatic logic [15:0] push_step(input logic [2:0] s);
        push_step = slg_pkg::WORD_STEP;
        if (s != slg_pkg::SLG_SRC_DATA) begin
            push_step = slg_pkg::WORD_STEP + slg_pkg::WORD_STEP;
        end
    endfunction

    // upper word of a counter push: zeros for a call, status byte for an exception
    function automatic logic [15:0] pair_hi(input logic [2:0] s, input logic [7:0] stat,
                                            input logic [6:0] top);
        pair_hi = {slg_pkg::HI_ZERO, 1'b0, top}; // see [RULE_03]
        if (s == slg_pkg::SLG_SRC_EXC) begin
            pair_hi = {stat, 1'b0, top}; // see [RULE_04]
        end
    endfunction

    // effective address for each operation
    always_comb begin
        ea = ea_in;
        acc = 1'b0;
        case (op)
            slg_pkg::SLG_OP_PUSH: begin
                ea = sp_q; // see [RULE_01]
                acc = 1'b1;
            end
            slg_pkg::SLG_OP_POP: begin
                ea = sp_q - slg_pkg::WORD_STEP; // see [RULE_02]
                acc = 1'b1;
            end
            slg_pkg::SLG_OP_EA: acc = 1'b1;
            default: acc = 1'b0;
        endcase
    end

    // a pop below one word would wrap its address past the floor test
    always_comb begin
        pop_wrap = is_pop(op) && (sp_q < slg_pkg::WORD_STEP);
    end

    // limit and floor compare
    always_comb begin
        over = acc && (ea > lim_q); // see [RULE_07] [RULE_08]
        under = acc && ((ea < slg_pkg::STACK_FLOOR) || pop_wrap); // see [RULE_09]
    end

    // an access commits only when no check refuses it
    always_comb begin
        commit_ok = !over && !under && !deny_c; // see [RULE_13]
    end

    slg_ram_gate u_gate (
        .addr(ea),
        .acc(acc),
        .bs_en(bs_en),
        .bs_lo(bs_lo),
        .bs_hi(bs_hi),
        .ss_en(ss_en),
        .ss_lo(ss_lo),
        .ss_hi(ss_hi),
        .from_boot(from_boot),
        .from_secure(from_secure),
        .deny(deny_c)
    );

    // pushed upper word formatting
    always_comb begin
        pc_hi = pair_hi(push_src, status_low_byte, pc[22:16]);
    end

    // next limit value; bit 0 is forced clear
    always_comb begin
        lim_d = lim_q;
        if (lim_we) begin
            lim_d = {lim_wdata[15:1], 1'b0}; // see [RULE_06]
        end
    end

    // next trap pulse and cause flags
    always_comb begin
        err_d = over || under; // see [RULE_13]
        ovf_d = over;
        unf_d = under;
        den_d = deny_c;
    end

    // next state of pointer and commit outputs
    always_comb begin
        sp_d = sp_q;
        mwe_d = 1'b0;
        mre_d = 1'b0;
        madr_d = ea;
        mwd_d = mwd_q;
        if (sp_we) begin
            sp_d = {sp_wdata[15:1], 1'b0};
        end else if (commit_ok) begin
            case (op)
                slg_pkg::SLG_OP_PUSH: begin
                    mwe_d = 1'b1;
                    sp_d = sp_q + push_step(push_src); // see [RULE_02]
                    if (push_src == slg_pkg::SLG_SRC_DATA) begin
                        mwd_d = {16'h0000, push_data};
                    end else begin
                        mwd_d = {pc_hi, pc[15:0]};
                    end
                end
                slg_pkg::SLG_OP_POP: begin
                    mre_d = 1'b1;
                    sp_d = ea; // see [RULE_02]
                end
                slg_pkg::SLG_OP_EA: begin
                    mre_d = 1'b1;
                end
                default: mre_d = 1'b0;
            endcase
        end
    end

    // registers; limit has no reset value
    always_ff @(posedge clk) begin
        if (ce) begin
            lim_q <= lim_d; // see [RULE_05]
        end
    end

    // registers with reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sp_q <= slg_pkg::SP_RESET;
            mwe_q <= 1'b0;
            mre_q <= 1'b0;
            madr_q <= 16'h0000;
            mwd_q <= 32'h0000_0000;
        end else if (ce) begin
            sp_q <= sp_d;
            mwe_q <= mwe_d;
            mre_q <= mre_d;
            madr_q <= madr_d;
            mwd_q <= mwd_d;
        end
    end

    // trap group registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            err_q <= 1'b0;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            den_q <= 1'b0;
        end else if (ce) begin
            err_q <= err_d;
            ovf_q <= ovf_d;
            unf_q <= unf_d;
            den_q <= den_d;
        end
    end

    assign stack_pointer_register = sp_q;
    assign stack_limit_register = lim_q;
    assign mem_we = mwe_q;
    assign mem_re = mre_q;
    assign mem_addr = madr_q;
    assign mem_wdata = mwd_q;
    assign stack_err = err_q;
    assign ovf = ovf_q;
    assign unf = unf_q;
    assign ram_deny = den_q;
endmodule

// File: core/slg_pkg.sv
package slg_pkg;
    localparam int ADDR_W = 16;
    localparam int PC_W = 23;
    localparam int PC_HI_W = 7;
    localparam logic [ADDR_W-1:0] STACK_FLOOR = 16'h0800;
    localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
    localparam logic [ADDR_W-1:0] SP_RESET = 16'h0800;
    localparam int LIMIT_LSB = 0;
    localparam logic [7:0] HI_ZERO = 8'h00;

    // operation requested by the core
    typedef enum logic [3:0] {
        SLG_OP_IDLE = 4'h1,
        SLG_OP_PUSH = 4'h2,
        SLG_OP_POP = 4'h4,
        SLG_OP_EA = 4'h8
    } slg_op_t;

    // source of a pushed word or word pair
    typedef enum logic [2:0] {
        SLG_SRC_DATA = 3'h1,
        SLG_SRC_CALL = 3'h2,
        SLG_SRC_EXC = 3'h4
    } slg_src_t;
endpackage

// File: core/slg_ram_gate.sv
`timescale 1ns/1ns
// secure ram segment gating
module slg_ram_gate (
    input wire logic [15:0] addr, // effective address
    input wire logic acc, // access attempt
    input wire logic bs_en, // boot secure ram enable
    input wire logic [15:0] bs_lo, // boot segment ram start
    input wire logic [15:0] bs_hi, // boot segment ram end
    input wire logic ss_en, // secure segment ram enable
    input wire logic [15:0] ss_lo, // secure segment ram start
    input wire logic [15:0] ss_hi, // secure segment ram end
    input wire logic from_boot, // code runs from boot flash
    input wire logic from_secure, // code runs from secure flash
    output logic deny // access refused
);
    // range test used for both segments
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // refuse foreign code in either segment
    always_comb begin
        deny = 1'b0;
        if (acc && bs_en && in_rng(addr, bs_lo, bs_hi) && !from_boot) begin
            deny = 1'b1; // see [RULE_11]
        end
        if (acc && ss_en && in_rng(addr, ss_lo, ss_hi) && !from_secure) begin
            deny = 1'b1; // see [RULE_12]
        end
    end
endmodule

// File: test/slg_sg_chk_asserts.sv
`timescale 1ns/1ns
module slg_sg_chk (
    input wire logic clk, // core clock
    input wire logic nrst, // async reset
    input wire logic ce, // clock enable
    input wire logic [3:0] op, // request
    input wire logic [2:0] push_src, // push source
    input wire logic [22:0] pc, // program counter
    input wire logic [7:0] status_low_byte, // status byte
    input wire logic [15:0] ea_in, // checked address
    input wire logic lim_we, // limit write
    input wire logic sp_we, // pointer write
    input wire logic bs_en, // boot ram gate
    input wire logic ss_en, // secure ram gate
    input wire logic [15:0] stack_pointer_register, // pointer
    input wire logic [15:0] stack_limit_register, // limit
    input wire logic mem_we, // write commit
    input wire logic mem_re, // read commit
    input wire logic [15:0] mem_addr, // address
    input wire logic [31:0] mem_wdata, // pushed pair
    input wire logic stack_err, // trap
    input wire logic ovf, // overflow
    input wire logic unf // underflow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [15:0] sp;
    logic [15:0] lim;
    logic go;
    logic pd;
    // plain request with gating off
    assign sp = stack_pointer_register;
    assign lim = stack_limit_register;
    assign go = ce && !sp_we && !bs_en && !ss_en;
    assign pd = go && op == 4'h2 && push_src == 3'h1;
    a_err_no_commit: assert property (stack_err |-> !mem_we && !mem_re)
        else $error("commit with trap");
    a_limit_bit_zero: assert property (ce && lim_we |=> !lim[0])
        else $error("limit bit 0 set");
    a_push_ok: assert property (pd && sp >= 16'h0800 && sp <= lim |=> mem_we
        && mem_addr == $past(sp) && sp == $past(sp) + 16'h0002) else $error("bad push");
    a_push_over: assert property (pd && sp > lim |=> stack_err && ovf && $stable(sp))
        else $error("missed overflow");
    a_pop_ok: assert property (go && op == 4'h4 && sp >= 16'h0802
        && 16'(sp - 16'h0002) <= lim |=> mem_re && mem_addr == sp) else $error("bad pop");
    a_pop_under: assert property (go && op == 4'h4 && sp < 16'h0802 |=> stack_err && unf)
        else $error("missed underflow");
    a_call_fmt: assert property (go && op == 4'h2 && push_src == 3'h2 |=>
        !mem_we || mem_wdata == {8'h00, 1'b0, $past(pc)}) else $error("bad call pair");
    a_exc_fmt: assert property (go && op == 4'h2 && push_src == 3'h4 |=>
        !mem_we || mem_wdata == {$past(status_low_byte), 1'b0, $past(pc)}) else $error("bad exc");
    a_ea_over: assert property (go && op == 4'h8 && ea_in > lim |=> stack_err && ovf)
        else $error("missed ea overflow");
    c_at_limit: cover property (pd && sp == lim);
    c_under: cover property (stack_err && unf);
    c_burst: cover property (mem_we ##1 mem_we);
endmodule
bind slg_stack_guard slg_sg_chk u_chk (.*);

// File: test/slg_core_model.sv
`timescale 1ns/1ns
// core trap side: counts trap events
module slg_core_model (
    input wire logic clk, // core clock
    input wire logic nrst, // async reset
    input wire logic stack_err, // trap pulse
    output int traps // traps taken
);
    // one event per pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            traps <= 0;
        end else if (stack_err) begin
            traps <= traps + 1;
        end
    end
endmodule

// File: test/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk = 0, nrst = 0, ce = 1, lim_we = 0, sp_we = 0, bs_en = 0, ss_en = 0;
    logic from_boot = 0, from_secure = 0, mem_we, mem_re, stack_err, ovf, unf, ram_deny;
    logic [3:0] op = 4'h1;
    logic [2:0] push_src = 3'h1;
    logic [15:0] push_data = 0, ea_in = 0, lim_wdata = 0, sp_wdata = 0, sp, lim, mem_addr, base;
    logic [15:0] bs_lo = 16'h0800, bs_hi = 16'h0802, ss_lo = 16'h0804, ss_hi = 16'h0806;
    logic [22:0] pc = 0;
    logic [7:0] status_low_byte = 0;
    logic [31:0] mem_wdata;
    int bad_count = 0, total_checks = 0, cyc = 0, traps;
    slg_stack_guard DUT (.clk, .nrst, .ce, .op, .push_src, .push_data, .pc, .status_low_byte,
        .ea_in, .lim_we, .lim_wdata, .sp_we, .sp_wdata, .bs_en, .bs_lo, .bs_hi, .ss_en, .ss_lo,
        .ss_hi, .from_boot, .from_secure, .stack_pointer_register(sp), .stack_limit_register(lim),
        .mem_we, .mem_re, .mem_addr, .mem_wdata, .stack_err, .ovf, .unf, .ram_deny);
    slg_core_model u_core (.clk, .nrst, .stack_err, .traps);
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one request, sampled after its answer edge
    task automatic req(input logic [3:0] o, input logic [2:0] s);
        @(posedge clk);
        op <= o;
        push_src <= s;
        @(posedge clk);
        op <= 4'h1;
        #1;
    endtask
    function automatic logic [31:0] pair(input logic [7:0] hi, input logic [22:0] p);
        return {hi, 1'b0, p};
    endfunction
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            stop_test;
        end
    end
    initial begin
        void'($urandom(32'h39df));
        base = 16'h0800 + 16'($urandom_range(4, 12)) * 16'h0002;
        repeat (4) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        lim_we <= 1;
        lim_wdata <= base | 16'h0001;
        @(posedge clk);
        lim_we <= 0;
        #1 chk(sp, 16'h0800);
        chk(lim, base);
        @(posedge clk);
        for (int i = 0; i <= (base - 16'h0800) / 2; i++) begin
            push_data <= 16'($urandom);
            req(4'h2, 3'h1);
            chk({mem_we, mem_addr}, {1'b1, 16'h0800 + 16'(i * 2)});
            chk(mem_wdata, {16'h0000, push_data});
        end
        req(4'h2, 3'h1);
        chk({stack_err, ovf, mem_we, sp}, {3'b110, base + 16'h0002});
        for (int i = 0; i <= (base - 16'h0800) / 2; i++) begin
            req(4'h4, 3'h1);
            chk({mem_re, mem_addr}, {1'b1, base - 16'(i * 2)});
        end
        req(4'h4, 3'h1);
        chk({stack_err, unf, mem_re, sp}, {3'b110, 16'h0800});
        for (int k = 0; k < 2; k++) begin
            pc <= 23'($urandom);
            status_low_byte <= 8'($urandom);
            req(4'h2, k[0] ? 3'h4 : 3'h2);
            chk(mem_wdata, pair(k[0] ? status_low_byte : 8'h00, pc));
        end
        chk(sp, 16'h0808);
        // clock enable low: a push is frozen out, all state holds
        ce <= 0;
        req(4'h2, 3'h1);
        chk({mem_we, sp}, {1'b1, 16'h0808});
        ce <= 1;
        ea_in <= base + 16'h0002;
        req(4'h8, 3'h1);
        chk({stack_err, ovf}, 2'b11);
        ea_in <= 16'h07fe;
        req(4'h8, 3'h1);
        chk({stack_err, unf}, 2'b11);
        for (int k = 0; k < 4; k++) begin
            {bs_en, ss_en} <= k[1] ? 2'b01 : 2'b10;
            {from_boot, from_secure} <= k[0] ? (k[1] ? 2'b01 : 2'b10) : 2'b00;
            ea_in <= k[1] ? ss_lo : bs_lo;
            req(4'h8, 3'h1);
            chk(ram_deny, !k[0]);
        end
        chk(traps, 4);
        stop_test;
    end
endmodule
